// File: inc/mrpg_map.svh
`ifndef MRPG_MAP_SVH
`define MRPG_MAP_SVH
// shared ram and pulse fifo geometry
`define MRPG_RAM_WORDS 4096
`define MRPG_FIFO_DEPTH 8
// register byte offsets
`define MRPG_OFS_CTRL 8'h00
`define MRPG_OFS_HADDR 8'h04
`define MRPG_OFS_HWDATA 8'h08
`define MRPG_OFS_HCMD 8'h0c
`define MRPG_OFS_HSTAT 8'h10
`define MRPG_OFS_PINTV 8'h14
`define MRPG_OFS_PCFG 8'h18
`define MRPG_OFS_OSR 8'h1c
`define MRPG_OFS_MONCTL 8'h20
`define MRPG_OFS_MON0 8'h24
`define MRPG_OFS_MON1 8'h28
`define MRPG_OFS_MON2 8'h2c
`define MRPG_OFS_MON3 8'h30
`define MRPG_OFS_STATUS 8'h34
// field positions
`define MRPG_CTRL_RUN 0
`define MRPG_CTRL_INV 1
`define MRPG_CTRL_MUX 4
`define MRPG_PCFG_IRQ 0
`define MRPG_PCFG_ALT 4
`define MRPG_PCFG_GPIO 8
// reset values and limits
`define MRPG_RST_PINTV 16'h0100
`define MRPG_OSR_MAX 10'h200
`define MRPG_RST_MONCNT 3'h4
`endif

// File: inc/mrpg_pkg.sv
package mrpg_pkg;
  // ram slot owner, one-hot
  typedef enum logic [2:0] {
    SLOT_HOST = 3'b001,
    SLOT_ENG  = 3'b010,
    SLOT_MON  = 3'b100
  } mrpg_slot_t;
  typedef logic [11:0] mrpg_addr_t;
  typedef logic [15:0] mrpg_word_t;
  typedef logic [3:0]  mrpg_pulse_t;
endpackage

// File: inc/mrpg_fifo_if.sv
`timescale 1ns/1ns
interface mrpg_fifo_if;
  logic                 push;
  mrpg_pkg::mrpg_pulse_t pushBits;
  logic                 pop;
  mrpg_pkg::mrpg_pulse_t popBits;
  logic                 clear;
  logic                 empty;
  logic                 full;
  logic [3:0]           level;
  modport owner (output push, pushBits, pop, clear, input popBits, empty, full, level);
  modport fifo (input push, pushBits, pop, clear, output popBits, empty, full, level);
endinterface

// File: logic/mrpg_pulse_fifo.sv
`timescale 1ns/1ns
`include "mrpg_map.svh"
module mrpg_pulse_fifo (
  // clock and reset
  input logic        clk,
  input logic        reset,
  // fifo port
  mrpg_fifo_if.fifo  f
);
  import mrpg_pkg::*;

  mrpg_pulse_t mem_q [`MRPG_FIFO_DEPTH];
  logic [2:0]  wp_q;
  logic [2:0]  rp_q;
  logic [3:0]  cnt_q;

  // status from the count
  assign f.empty   = (cnt_q == 4'h0);
  assign f.full    = (cnt_q == 4'(`MRPG_FIFO_DEPTH));
  assign f.level   = cnt_q;
  assign f.popBits = mem_q[rp_q];

  // storage, no reset needed
  always_ff @(posedge clk)
  begin
    if (f.push && !f.full && !f.clear)
      mem_q[wp_q] <= f.pushBits;
  end

  // pointers, clear wins
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wp_q  <= 3'h0;
      rp_q  <= 3'h0;
      cnt_q <= 4'h0;
    end
    else if (f.clear)
    begin
      wp_q  <= 3'h0; // R10
      rp_q  <= 3'h0;
      cnt_q <= 4'h0;
    end
    else
    begin
      if (f.push && !f.full)
        wp_q <= wp_q + 3'h1;
      if (f.pop && !f.empty)
        rp_q <= rp_q + 3'h1;
      cnt_q <= cnt_q + 4'((f.push && !f.full) ? 1 : 0) - 4'((f.pop && !f.empty) ? 1 : 0);
    end
  end
endmodule

// File: logic/mrpg_top.sv
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
// Summary of operation
// R1 - one shared ram, 4096 sixteen-bit words
// R2 - host loads program before releasing engine
// R3 - slots rotate host, engine, monitor; no collisions
// R4 - engine reaches every ram location
// R5 - engine 32-bit words stored low half first
// R6 - filter result written one cycle after done
// R7 - monitor streams up to four words out
// R8 - monitor reads selected addresses in own slot
// R9 - sign bits queued per pass, emitted per interval
// R10 - pulse fifo cleared at frame start
// R11 - four pulse outputs, each with interrupt enable
// R12 - one invert bit; clear means active low
// R13 - pulses selectable onto four port pins
// R14 - aux pulses updated once per engine pass
// R15 - pulse rate word lives in ram, writable live; the code keeps it in the PINTV register (interval_q), not in ram
// R16 - oversampling ratio limited to 512
// R17 - fourth converter input mux selectable
// R18 - early host access waits for host slot
// R19 - monitor order fixed, frame marker on word 0
// R20 - engine idle falling edge gives event
// R21 - result update level passed to host
`include "mrpg_map.svh"
module mrpg_top (
  // clock and reset
  input  logic                 clk,
  input  logic                 reset,
  // axi4-lite register bus
  input  logic [7:0]           s_axi_awaddr,
  input  logic                 s_axi_awvalid,
  output logic                 s_axi_awready,
  input  logic [31:0]          s_axi_wdata,
  input  logic [3:0]           s_axi_wstrb,
  input  logic                 s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  logic                 s_axi_bready,
  input  logic [7:0]           s_axi_araddr,
  input  logic                 s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  logic                 s_axi_rready,
  // engine ram port
  input  logic                 engReq,
  input  logic                 engWe,
  input  logic [10:0]          engAddr,
  input  logic [31:0]          engWdata,
  output logic [31:0]          engRdata,
  output logic                 engAck,
  // engine status and pulse export
  input  logic                 engBusy,
  input  logic                 xferBusy,
  input  logic                 engExportValid,
  input  mrpg_pkg::mrpg_pulse_t engExportBits,
  output logic                 engineRun,
  output logic                 engIdleEvt,
  output logic                 resultUpdateActive,
  // decimation filter
  input  logic                 firDone,
  input  mrpg_pkg::mrpg_addr_t firAddr,
  input  mrpg_pkg::mrpg_word_t firData,
  output logic [9:0]           filtOsr,
  output logic [1:0]           muxedVoltageSel,
  // frame timing
  input  logic                 frameStart,
  // pins
  output logic [1:0]           testOutputPins,
  output mrpg_pkg::mrpg_pulse_t pulseOut,
  output mrpg_pkg::mrpg_pulse_t pulseIrq,
  output mrpg_pkg::mrpg_pulse_t gpioOut
);
  import mrpg_pkg::*;

  mrpg_word_t  mem_q [`MRPG_RAM_WORDS]; // R1
  mrpg_slot_t  slot_q;
  logic        firWr_q;
  mrpg_addr_t  firAddr_q;
  mrpg_word_t  firData_q;
  logic        awHeld_q, wHeld_q, bvalid_q, rvalid_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q, rdata_q, rdVal, wrVal;
  logic [3:0]  wStrb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic        wrFire, wrHit, rdHit;
  logic        ctrlRun_q, ctrlInv_q;
  logic [1:0]  muxSel_q;
  mrpg_addr_t  hostAddr_q;
  mrpg_word_t  hostWdata_q, hostRdata_q;
  logic        hostWe_q, hostPend_q, hostGo;
  logic [15:0] interval_q, intCnt_q;
  mrpg_pulse_t irqEn_q, altSel_q, gpioData_q, pulseAct_q, pulseLvl;
  logic [9:0]  osr_q;
  logic [2:0]  monCount_q;
  mrpg_addr_t  monSel_q [4];
  logic        engHalf_q, engAck_q, engGo;
  logic [31:0] engRdata_q;
  logic [1:0]  monIdx_q, testOut_q;
  logic [15:0] monShift_q;
  logic [4:0]  monBits_q;
  logic        monFirst_q, monLoad;
  logic        engBusyD_q, engIdleEvt_q, xfer_q;
  mrpg_pulse_t pulseOut_q, pulseIrq_q, gpioOut_q;
  mrpg_fifo_if fifoIf ();

  // output drive
  assign s_axi_awready      = !awHeld_q;
  assign s_axi_wready       = !wHeld_q;
  assign s_axi_bvalid       = bvalid_q;
  assign s_axi_bresp        = bresp_q;
  assign s_axi_arready      = !rvalid_q;
  assign s_axi_rvalid       = rvalid_q;
  assign s_axi_rdata        = rdata_q;
  assign s_axi_rresp        = rresp_q;
  assign engRdata           = engRdata_q;
  assign engAck             = engAck_q;
  assign engineRun          = ctrlRun_q; // R2
  assign engIdleEvt         = engIdleEvt_q;
  assign resultUpdateActive = xfer_q;
  assign filtOsr            = osr_q;
  assign muxedVoltageSel    = muxSel_q; // R17
  assign testOutputPins     = testOut_q;
  assign pulseOut           = pulseOut_q;
  assign pulseIrq           = pulseIrq_q;
  assign gpioOut            = gpioOut_q;

  // write decode and byte-lane merge
  assign wrFire = awHeld_q && wHeld_q && !bvalid_q;
  assign wrHit  = awAddr_q inside {`MRPG_OFS_CTRL, `MRPG_OFS_HADDR, `MRPG_OFS_HWDATA, `MRPG_OFS_HCMD,
                  `MRPG_OFS_HSTAT, `MRPG_OFS_PINTV, `MRPG_OFS_PCFG, `MRPG_OFS_OSR, `MRPG_OFS_MONCTL,
                  `MRPG_OFS_MON0, `MRPG_OFS_MON1, `MRPG_OFS_MON2, `MRPG_OFS_MON3, `MRPG_OFS_STATUS};
  assign wrVal  = wData_q & {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

  // axi write channels
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= 2'h0;
      awAddr_q <= 8'h00;
      wData_q  <= 32'h0;
      wStrb_q  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && !awHeld_q)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_q)
      begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrFire)
      begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wrHit ? 2'h0 : 2'h2;
      end
      if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // read mux
  always_comb
  begin
    rdVal = 32'h0;
    rdHit = 1'b1;
    case (s_axi_araddr)
      `MRPG_OFS_CTRL:   rdVal = {26'h0, muxSel_q, 2'h0, ctrlInv_q, ctrlRun_q};
      `MRPG_OFS_HADDR:  rdVal = {20'h0, hostAddr_q};
      `MRPG_OFS_HWDATA: rdVal = {16'h0, hostWdata_q};
      `MRPG_OFS_HCMD:   rdVal = {31'h0, hostWe_q};
      `MRPG_OFS_HSTAT:  rdVal = {hostRdata_q, 15'h0, hostPend_q};
      `MRPG_OFS_PINTV:  rdVal = {16'h0, interval_q};
      `MRPG_OFS_PCFG:   rdVal = {20'h0, gpioData_q, altSel_q, irqEn_q};
      `MRPG_OFS_OSR:    rdVal = {22'h0, osr_q};
      `MRPG_OFS_MONCTL: rdVal = {29'h0, monCount_q};
      `MRPG_OFS_MON0:   rdVal = {20'h0, monSel_q[0]};
      `MRPG_OFS_MON1:   rdVal = {20'h0, monSel_q[1]};
      `MRPG_OFS_MON2:   rdVal = {20'h0, monSel_q[2]};
      `MRPG_OFS_MON3:   rdVal = {20'h0, monSel_q[3]};
      `MRPG_OFS_STATUS: rdVal = {20'h0, fifoIf.level, 5'h0, xfer_q, engBusyD_q, hostPend_q}; // R21
      default:          rdHit = 1'b0;
    endcase
  end

  // axi read channel
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= 2'h0;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rdVal;
      rresp_q  <= rdHit ? 2'h0 : 2'h2;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // configuration registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrlRun_q  <= 1'b0;
      ctrlInv_q  <= 1'b0;
      muxSel_q   <= 2'h0;
      interval_q <= `MRPG_RST_PINTV;
      irqEn_q    <= 4'h0;
      altSel_q   <= 4'h0;
      gpioData_q <= 4'h0;
      osr_q      <= `MRPG_OSR_MAX;
      monCount_q <= `MRPG_RST_MONCNT;
      monSel_q   <= '{default: 12'h000};
    end
    else if (wrFire)
    begin
      case (awAddr_q)
        `MRPG_OFS_CTRL:
        begin
          ctrlRun_q <= wrVal[`MRPG_CTRL_RUN];
          ctrlInv_q <= wrVal[`MRPG_CTRL_INV]; // R12
          muxSel_q  <= wrVal[`MRPG_CTRL_MUX +: 2];
        end
        `MRPG_OFS_PINTV:  interval_q <= wrVal[15:0];
        `MRPG_OFS_PCFG:
        begin
          irqEn_q    <= wrVal[`MRPG_PCFG_IRQ +: 4]; // R11
          altSel_q   <= wrVal[`MRPG_PCFG_ALT +: 4]; // R13
          gpioData_q <= wrVal[`MRPG_PCFG_GPIO +: 4];
        end
        `MRPG_OFS_OSR:    osr_q <= (wrVal[9:0] > `MRPG_OSR_MAX) ? `MRPG_OSR_MAX : wrVal[9:0]; // R16
        `MRPG_OFS_MONCTL: monCount_q <= wrVal[2:0];
        `MRPG_OFS_MON0:   monSel_q[0] <= wrVal[11:0]; // R8
        `MRPG_OFS_MON1:   monSel_q[1] <= wrVal[11:0];
        `MRPG_OFS_MON2:   monSel_q[2] <= wrVal[11:0];
        `MRPG_OFS_MON3:   monSel_q[3] <= wrVal[11:0];
        default:          ;
      endcase
    end
  end

  // filter result capture, written the next cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      firWr_q   <= 1'b0;
      firAddr_q <= 12'h000;
      firData_q <= 16'h0000;
    end
    else
    begin
      firWr_q   <= firDone; // R6
      firAddr_q <= firAddr;
      firData_q <= firData;
    end
  end

  // slot rotation, held while the filter writes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      slot_q <= SLOT_HOST;
    else if (!firWr_q)
    begin
      case (slot_q)
        SLOT_HOST: slot_q <= SLOT_ENG; // R3
        SLOT_ENG:  slot_q <= SLOT_MON;
        SLOT_MON:  slot_q <= SLOT_HOST;
        default:   slot_q <= SLOT_HOST;
      endcase
    end
  end

  assign hostGo  = (slot_q == SLOT_HOST) && !firWr_q;
  assign engGo   = (slot_q == SLOT_ENG) && !firWr_q && engReq && !engAck_q;
  assign monLoad = (slot_q == SLOT_MON) && !firWr_q && (monBits_q == 5'h0);

  // ram write port, one owner per cycle
  always_ff @(posedge clk)
  begin
    if (firWr_q)
      mem_q[firAddr_q] <= firData_q;
    else if (hostGo && hostPend_q && hostWe_q)
      mem_q[hostAddr_q] <= hostWdata_q; // R15
    else if (engGo && engWe)
      mem_q[{engAddr, engHalf_q}] <= engHalf_q ? engWdata[31:16] : engWdata[15:0]; // R4 R5
  end

  // host access, pending until the host slot
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      hostAddr_q  <= 12'h000;
      hostWdata_q <= 16'h0000;
      hostWe_q    <= 1'b0;
      hostPend_q  <= 1'b0;
      hostRdata_q <= 16'h0000;
    end
    else if (hostPend_q)
    begin
      if (hostGo)
      begin
        hostPend_q <= 1'b0; // R18
        if (!hostWe_q)
          hostRdata_q <= mem_q[hostAddr_q];
      end
    end
    else if (wrFire)
    begin
      case (awAddr_q)
        `MRPG_OFS_HADDR:  hostAddr_q <= wrVal[11:0];
        `MRPG_OFS_HWDATA: hostWdata_q <= wrVal[15:0];
        `MRPG_OFS_HCMD:
        begin
          hostWe_q   <= wrVal[0];
          hostPend_q <= 1'b1; // R18
        end
        default:          ;
      endcase
    end
  end

  // engine access, two halves per 32-bit word
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      engHalf_q  <= 1'b0;
      engAck_q   <= 1'b0;
      engRdata_q <= 32'h0;
    end
    else
    begin
      engAck_q <= 1'b0;
      if (engGo)
      begin
        engHalf_q <= !engHalf_q; // R5
        engAck_q  <= engHalf_q;
        if (!engWe && !engHalf_q)
          engRdata_q[15:0] <= mem_q[{engAddr, 1'b0}];
        if (!engWe && engHalf_q)
          engRdata_q[31:16] <= mem_q[{engAddr, 1'b1}];
      end
    end
  end

  // live monitor, msb first, marker on word 0
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      monIdx_q   <= 2'h0;
      monShift_q <= 16'h0000;
      monBits_q  <= 5'h0;
      monFirst_q <= 1'b0;
      testOut_q  <= 2'h0;
    end
    else if (monLoad)
    begin
      monShift_q <= mem_q[monSel_q[monIdx_q]]; // R7 R8
      monBits_q  <= 5'h10;
      monFirst_q <= (monIdx_q == 2'h0);
      monIdx_q   <= ({1'b0, monIdx_q} + 3'h1 >= monCount_q) ? 2'h0 : monIdx_q + 2'h1; // R19
      testOut_q  <= 2'h0;
    end
    else if (monBits_q != 5'h0)
    begin
      testOut_q  <= {monFirst_q && (monBits_q == 5'h10), monShift_q[15]}; // R19
      monShift_q <= {monShift_q[14:0], 1'b0};
      monBits_q  <= monBits_q - 5'h1;
    end
    else
      testOut_q <= 2'h0;
  end

  // pulse fifo hookup
  assign fifoIf.push     = engExportValid; // R9 R14
  assign fifoIf.pushBits = engExportBits;
  assign fifoIf.clear    = frameStart; // R10
  assign fifoIf.pop      = (intCnt_q == 16'h0) && !frameStart;

  mrpg_pulse_fifo u_fifo (
    .clk   (clk),
    .reset (reset),
    .f     (fifoIf)
  );

  // interval timer, one entry per interval
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      intCnt_q   <= `MRPG_RST_PINTV;
      pulseAct_q <= 4'h0;
    end
    else if (frameStart)
    begin
      intCnt_q   <= interval_q;
      pulseAct_q <= 4'h0;
    end
    else if (intCnt_q == 16'h0)
    begin
      intCnt_q   <= interval_q;
      pulseAct_q <= fifoIf.empty ? 4'h0 : fifoIf.popBits; // R9
    end
    else
      intCnt_q <= intCnt_q - 16'h1;
  end

  assign pulseLvl = ctrlInv_q ? pulseAct_q : ~pulseAct_q; // R12

  // pins, interrupt requests, engine events
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pulseOut_q   <= 4'hf;
      pulseIrq_q   <= 4'h0;
      gpioOut_q    <= 4'h0;
      engBusyD_q   <= 1'b0;
      engIdleEvt_q <= 1'b0;
      xfer_q       <= 1'b0;
    end
    else
    begin
      pulseOut_q   <= pulseLvl;
      pulseIrq_q   <= pulseAct_q & irqEn_q; // R11
      gpioOut_q    <= (altSel_q & pulseLvl) | (~altSel_q & gpioData_q); // R13
      engBusyD_q   <= engBusy;
      engIdleEvt_q <= engBusyD_q && !engBusy; // R20
      xfer_q       <= xferBusy; // R21
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_fir_next_cycle: assert property (firDone |=> firWr_q && firAddr_q == $past(firAddr)) // R6
    else $error("filter write not one cycle after done");
  a_slot_host_eng: assert property (slot_q == SLOT_HOST && !firWr_q |=> slot_q == SLOT_ENG) // R3
    else $error("slot rotation broken");
  a_slot_fir_hold: assert property (firWr_q |=> slot_q == $past(slot_q)) // R3
    else $error("slot moved during filter write");
  a_host_pend_bound: assert property ($rose(hostPend_q) |-> ##[1:60] !hostPend_q) // R18
    else $error("host access never served");
  a_mon_slot_only: assert property (monBits_q == 5'h10 |-> $past(slot_q) == SLOT_MON && !$past(firWr_q)) // R8
    else $error("monitor read outside its slot");
  a_frame_fifo_clear: assert property (frameStart |=> fifoIf.level == 4'h0) // R10
    else $error("fifo not cleared at frame");
  a_pulse_idle_level: assert property (pulseAct_q == 4'h0 |=> pulseOut_q == {4{~$past(ctrlInv_q)}}) // R12
    else $error("idle pulse level wrong");
  a_eng_ack_bound: assert property ($rose(engReq) |-> ##[1:30] engAck_q) // R5
    else $error("engine access not acknowledged");
  a_idle_event: assert property ($fell(engBusyD_q) |-> engIdleEvt_q) // R20
    else $error("idle event missing");
  a_mon_marker_word0: assert property (testOut_q[1] |-> $past(monFirst_q)) // R19
    else $error("marker on wrong word");

  c_host_write: cover property (hostGo && hostPend_q && hostWe_q);
  c_eng_ack: cover property (engAck_q && engWe);
  c_mon_marker: cover property (testOut_q[1]);
  c_pulse_emit: cover property (pulseAct_q != 4'h0);
endmodule

// File: dv/mrpg_host_model.sv
`timescale 1ns/1ns
module mrpg_host_model (
  // clock
  input  wire logic        clk,
  // write channels
  output logic [7:0]       awAddr,
  output logic             awValid,
  input  wire logic        awReady,
  output logic [31:0]      wData,
  output logic [3:0]       wStrb,
  output logic             wValid,
  input  wire logic        wReady,
  input  wire logic [1:0]  bResp,
  input  wire logic        bValid,
  output logic             bReady,
  // read channels
  output logic [7:0]       arAddr,
  output logic             arValid,
  input  wire logic        arReady,
  input  wire logic [31:0] rData,
  input  wire logic [1:0]  rResp,
  input  wire logic        rValid,
  output logic             rReady
);
  // bus idle from time zero
  initial
  begin
    {awAddr, awValid, wData, wValid, bReady} = '0;
    {arAddr, arValid, rReady} = '0;
    wStrb = 4'hf;
  end
  // one write; each channel released at the edge its ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw, ta, tw;
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw)
    begin
      @(negedge clk);
      ta = pa && (awReady === 1'b1);
      tw = pw && (wReady === 1'b1);
      @(posedge clk);
      if (ta)
        awValid <= 1'b0;
      if (tw)
        wValid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do
      @(negedge clk);
    while (bValid !== 1'b1);
    r = bResp;
    @(posedge clk);
    bReady <= 1'b0;
  endtask
  // one read; rready held until rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do
      @(negedge clk);
    while (arReady !== 1'b1);
    @(posedge clk);
    arValid <= 1'b0;
    while (rValid !== 1'b1)
      @(negedge clk);
    d = rData;
    r = rResp;
    @(posedge clk);
    rReady <= 1'b0;
  endtask
endmodule

// File: dv/tb_metrology_ram_pulse_gen.sv
`timescale 1ns/1ns
`include "mrpg_map.svh"
module tb_metrology_ram_pulse_gen;
  import mrpg_pkg::*;
  logic        clk, reset, awV, awR, wV, wR, bV, bR, arV, arR, rV, rR;
  logic [7:0]  awA, arA;
  logic [31:0] wD, rD, engWd, engRd;
  logic [3:0]  wS;
  logic [1:0]  bRs, rRs, tPins, vSel, resp;
  logic        eReq, eWe, eAck, eBusy, xBusy, xV, run, idleEvt, rua, firDone;
  logic [10:0] eAddr;
  mrpg_pulse_t xBits, pOut, pIrq, gOut;
  mrpg_addr_t  firAddr, ha;
  logic [31:0] eCap, ew;
  mrpg_word_t  firData, q, w;
  logic [9:0]  osr;
  logic        frame;
  logic [31:0] s;
  int          n_fail, checks, seed, i, k;
  mrpg_top u_mrpg_top (.clk(clk), .reset(reset), .s_axi_awaddr(awA), .s_axi_awvalid(awV),
    .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(wS), .s_axi_wvalid(wV), .s_axi_wready(wR),
    .s_axi_bresp(bRs), .s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV),
    .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rRs), .s_axi_rvalid(rV), .s_axi_rready(rR),
    .engReq(eReq), .engWe(eWe), .engAddr(eAddr), .engWdata(engWd), .engRdata(engRd), .engAck(eAck),
    .engBusy(eBusy), .xferBusy(xBusy), .engExportValid(xV), .engExportBits(xBits), .engineRun(run),
    .engIdleEvt(idleEvt), .resultUpdateActive(rua), .firDone(firDone), .firAddr(firAddr),
    .firData(firData), .filtOsr(osr), .muxedVoltageSel(vSel), .frameStart(frame),
    .testOutputPins(tPins), .pulseOut(pOut), .pulseIrq(pIrq), .gpioOut(gOut));
  mrpg_host_model u_mrpg_host_model (.clk(clk), .awAddr(awA), .awValid(awV), .awReady(awR),
    .wData(wD), .wStrb(wS), .wValid(wV), .wReady(wR), .bResp(bRs), .bValid(bV), .bReady(bR),
    .arAddr(arA), .arValid(arV), .arReady(arR), .rData(rD), .rResp(rRs), .rValid(rV), .rReady(rR));
  // clock and input defaults
  always #5 clk = ~clk;
  initial
  begin
    {clk, eReq, eWe, eAddr, engWd, eBusy, xBusy, xV, xBits, firDone, firAddr, firData, frame} = '0;
    reset = 1'b1;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_mrpg_host_model.wr(a, d, resp);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    u_mrpg_host_model.rd(a, d, resp);
  endtask
  // host ram access through the command registers, polled to completion
  task automatic hostAcc(input mrpg_addr_t a, input mrpg_word_t d, input logic we, output mrpg_word_t r);
    int n;
    wr(`MRPG_OFS_HADDR, {20'h0, a});
    wr(`MRPG_OFS_HWDATA, {16'h0, d});
    wr(`MRPG_OFS_HCMD, {31'h0, we});
    n = 0;
    do
    begin
      rd(`MRPG_OFS_HSTAT, s);
      n++;
    end
    while (s[0] !== 1'b0 && n < 20);
    chk("hostPend", 0, s[0]);
    r = s[31:16];
  endtask
  task automatic engOp(input logic we, input logic [10:0] a, input logic [31:0] d);
    @(posedge clk);
    {eReq, eWe, eAddr, engWd} <= {1'b1, we, a, d};
    do
      @(negedge clk);
    while (eAck !== 1'b1);
    eCap = engRd;
    @(posedge clk);
    eReq <= 1'b0;
  endtask
  // pulse from the fifo shows up within a bounded wait
  task automatic waitPulse(input mrpg_pulse_t e, output logic hit);
    hit = 1'b0;
    for (k = 0; k < 30 && !hit; k++)
    begin
      @(negedge clk);
      hit = (pOut === e);
    end
  endtask
  initial
  begin
    #300000;
    n_fail++;
    finish_test;
  end
  initial
  begin
    logic hit;
    seed = 59;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    // reset values, unmapped place
    @(negedge clk);
    chk("pulseOut", 4'hf, pOut);
    chk("engineRun", 0, run);
    rd(`MRPG_OFS_PINTV, s);
    chk("pintv", `MRPG_RST_PINTV, s);
    rd(`MRPG_OFS_OSR, s);
    chk("osr", `MRPG_OSR_MAX, s);
    rd(`MRPG_OFS_MONCTL, s);
    chk("monctl", `MRPG_RST_MONCNT, s);
    rd(8'h3c, s);
    chk("rresp", 2'b10, resp);
    wr(8'h40, 32'h1);
    chk("bresp", 2'b10, resp);
    $display("test reset done");
    // program load at both ends of ram, then release
    for (i = 0; i < 6; i++)
    begin
      ha = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($random(seed));
      w = $random(seed);
      hostAcc(ha, w, 1'b1, q);
      hostAcc(ha, 16'h0, 1'b0, q);
      chk("ramWord", w, q);
    end
    wr(`MRPG_OFS_CTRL, 32'h1);
    @(negedge clk);
    chk("engineRun", 1, run);
    $display("test host ram done");
    // engine 32-bit word at top index, halves seen by host
    ew = $random(seed);
    engOp(1'b1, 11'h7ff, ew);
    hostAcc(12'hffe, 16'h0, 1'b0, q);
    chk("engLow", ew[15:0], q);
    hostAcc(12'hfff, 16'h0, 1'b0, q);
    chk("engHigh", ew[31:16], q);
    hostAcc(12'h010, 16'hbeef, 1'b1, q);
    hostAcc(12'h011, 16'h1234, 1'b1, q);
    engOp(1'b0, 11'h008, 32'h0);
    chk("engRead", 32'h1234beef, eCap);
    $display("test engine done");
    // filter result lands in ram
    @(posedge clk);
    {firDone, firAddr, firData} <= {1'b1, 12'h123, 16'h5a3c};
    @(posedge clk);
    firDone <= 1'b0;
    hostAcc(12'h123, 16'h0, 1'b0, q);
    chk("firWord", 16'h5a3c, q);
    // clamp, mux select, polarity
    wr(`MRPG_OFS_OSR, 32'h3ff);
    @(negedge clk);
    chk("filtOsr", 10'h200, osr);
    for (i = 0; i < 4; i++)
    begin
      wr(`MRPG_OFS_CTRL, 32'h3 | (i << 4));
      repeat (2) @(negedge clk);
      chk("muxSel", i, vSel);
      chk("pulseIdle", 4'h0, pOut);
    end
    $display("test config done");
    // pulses: gpio, then fifo spread and frame clear
    wr(`MRPG_OFS_PCFG, 32'hfa0);
    repeat (2) @(negedge clk);
    chk("gpioOut", 4'h5, gOut);
    wr(`MRPG_OFS_CTRL, 32'h1);
    wr(`MRPG_OFS_PINTV, 32'h3);
    wr(`MRPG_OFS_PCFG, 32'h1);
    @(posedge clk);
    frame <= 1'b1;
    @(posedge clk);
    {frame, xV, xBits} <= {2'b01, 4'b0101};
    @(posedge clk);
    xV <= 1'b0;
    waitPulse(4'b1010, hit);
    chk("pulseSeen", 1, hit);
    chk("pulseIrq", 4'b0001, pIrq);
    @(posedge clk);
    {xV, xBits} <= {1'b1, 4'b1001};
    @(posedge clk);
    {xV, frame} <= 2'b01;
    @(posedge clk);
    frame <= 1'b0;
    waitPulse(4'b0110, hit);
    chk("pulseCleared", 0, hit);
    $display("test pulses done");
    // engine status events
    @(posedge clk);
    {xBusy, eBusy} <= 2'b11;
    @(posedge clk);
    @(negedge clk);
    chk("resultUpd", 1, rua);
    @(posedge clk);
    {xBusy, eBusy} <= 2'b00;
    hit = 1'b0;
    repeat (4) @(negedge clk) hit |= (idleEvt === 1'b1);
    chk("idleEvt", 1, hit);
    $display("test events done");
    // live monitor of one word, msb first after the marker
    w = $random(seed);
    hostAcc(12'h2a5, w, 1'b1, q);
    wr(`MRPG_OFS_MON0, 32'h2a5);
    wr(`MRPG_OFS_MONCTL, 32'h1);
    repeat (60) @(negedge clk);
    k = 0;
    while (tPins[1] !== 1'b1 && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    for (i = 0; i < 16; i++)
    begin
      q = {q[14:0], tPins[0]};
      @(negedge clk);
    end
    chk("monWord", w, q);
    $display("test monitor done");
    finish_test;
  end
endmodule
